/* qd_pkg.sv */
// Shared constants and types for the quad converter serial write link
//
// How it works
// - Frame falling edge starts; shift bits on falls
// - Host never drops frame with clock fall
// - Sixteenth fall executes the captured command word
// - Later clocks ignored until frame rises again
// - Host holds frame high before next frame
// - Host idles frame and data lines low
// - Word: channel two, mode two, data ten, two low bits unused
// - Four operations: load, load-update, all, power-down
// - Code straight binary, most significant bit first
// - Early frame rise discards word, nothing changes
// - Reset clears registers, outputs at zero
// - Mode eleven powers down all four channels
// - Channel bits pick power-down output termination
// - Registers kept through power-down
// - Outputs return after wake-up delay
// - Host stops clock, lines low in power-down
// - Serial clock never above forty megahertz
`default_nettype none
package qd_pkg;
   // ****************************************
   // Word layout
   // ****************************************
   localparam int NUM_CH = 4;
   localparam int CODE_BITS = 10;
   localparam int CH_HI = 15;
   localparam int CH_LO = 14;
   localparam int OP_HI = 13;
   localparam int OP_LO = 12;
   localparam int CODE_HI = 11;
   localparam int CODE_LO = 2;
   localparam logic [3:0] LAST_BIT = 4'hf;
   localparam logic [9:0] CODE_RESET = 10'h000;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 100;
   localparam int WAKE_NS = 800;
   localparam int WAKE_RAW = WAKE_NS / CLK_NS;
   localparam logic [3:0] WAKE_CYC =
      (WAKE_RAW < 1) ? 4'h1 : 4'(WAKE_RAW);
   localparam int SCLK_MAX_MHZ = 40;
   localparam int SCLK_HALF_NS = 400;
   localparam int HALF_RAW = SCLK_HALF_NS / CLK_NS;
   localparam logic [2:0] DIV_LAST =
      (HALF_RAW < 2) ? 3'h0 : 3'(HALF_RAW - 1);

   // ****************************************
   // Host register map
   // ****************************************
   localparam logic [7:0] REG_WORD = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      OP_LOAD, OP_LOAD_UPD, OP_ALL_UPD, OP_PWRDN
   } qd_op_t;
   typedef enum logic [1:0] {
      TERM_HIZ, TERM_2K5, TERM_100K
   } qd_term_t;
   typedef enum logic [1:0] {
      H_IDLE, H_LEAD, H_SHIFT, H_TAIL
   } qd_hstate_t;
endpackage
`default_nettype wire

/* qd_link_if.sv */
// Three-wire serial write link between host and converter
`default_nettype none
interface qd_link_if;
   logic frame_n;
   logic sclk;
   logic serial_data_in;
   modport dev (
      input frame_n,
      input sclk,
      input serial_data_in
   );
   modport host (
      output frame_n,
      output sclk,
      output serial_data_in
   );
endinterface
`default_nettype wire

/* qd_host.sv */
// Host end: register port in, serial write frames out
`default_nettype none
module qd_host (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   qd_link_if.host link
);
   import qd_pkg::*;

   typedef struct packed {
      qd_hstate_t st;
      logic [2:0] div;
      logic frame_n;
      logic sclk;
      logic din;
      logic [15:0] sh;
      logic [15:0] word;
      logic [3:0] bits;
      logic [7:0] sent;
      logic [31:0] rdata;
   } qd_host_t;

   qd_host_t s;
   qd_host_t next_s;
   logic tick;

   // Half-period enable of the serial clock
   assign tick = (s.div == DIV_LAST);

   // Register port and frame sequencer
   always_comb begin
      next_s = s;
      next_s.rdata = 32'h0000_0000;
      if (s.st != H_IDLE) begin
         next_s.div = tick ? 3'h0 : s.div + 3'h1;
      end
      if (rd) begin
         if (addr == REG_WORD) begin
            next_s.rdata = {16'h0000, s.word};
         end else if (addr == REG_STATUS) begin
            next_s.rdata = {16'h0000, s.sent, 7'h00,
                            s.st != H_IDLE};
         end
      end
      case (s.st)
         H_IDLE: begin
            // Writes while busy are dropped
            if (wr && addr == REG_WORD) begin
               next_s.word = wdata[15:0];
               next_s.sh = wdata[15:0];
               next_s.frame_n = 1'b1;
               next_s.div = 3'h0;
               next_s.st = H_LEAD;
            end
         end
         H_LEAD: begin
            // Falls while the clock sits low, never with a fall
            if (tick) begin
               next_s.frame_n = 1'b0;
               next_s.st = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (tick && !s.sclk) begin
               // Data moves on the rise, far from the fall
               next_s.sclk = 1'b1;
               next_s.din = s.sh[15];
               next_s.sh = {s.sh[14:0], 1'b0};
            end else if (tick) begin
               next_s.sclk = 1'b0;
               next_s.bits = s.bits + 4'h1;
               if (s.bits == LAST_BIT) begin
                  next_s.st = H_TAIL;
               end
            end
         end
         H_TAIL: begin
            // Data held past the last fall, then idled low
            if (tick) begin
               next_s.din = 1'b0;
               next_s.sent = s.sent + 8'h01;
               next_s.st = H_IDLE;
            end
         end
         default: next_s.st = H_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign link.frame_n = s.frame_n;
   assign link.sclk = s.sclk;
   assign link.serial_data_in = s.din;
endmodule
`default_nettype wire

/* qd_dev.sv */
// Device end: serial word capture and channel control
`default_nettype none
module qd_dev (
   input wire logic clk,
   input wire logic nrst,
   qd_link_if.dev link,
   output logic [3:0][9:0] out_code,
   output logic out_on,
   output qd_pkg::qd_term_t out_term,
   output logic powered_down
);
   import qd_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic f1;
      logic f2;
      logic fp;
      logic c1;
      logic c2;
      logic cp;
      logic d1;
      logic d2;
      logic armed;
      logic [3:0] cnt;
      logic [14:0] shreg;
      logic [3:0][9:0] in_reg;
      logic [3:0][9:0] dac_reg;
      logic pd;
      qd_term_t term;
      logic [3:0] wake;
      logic on;
   } qd_dev_t;

   qd_dev_t s;
   qd_dev_t next_s;

   // ****************************************
   // Decoded link events
   // ****************************************
   logic frame_fall;
   logic frame_high;
   logic sclk_fall;
   logic word_done;
   logic [15:0] word;
   logic [1:0] ch;
   qd_op_t op;
   logic [9:0] code;

   // Edges seen only after both synchroniser stages
   assign frame_fall = s.fp && !s.f2;
   assign frame_high = s.f2;
   assign sclk_fall = s.cp && !s.c2;

   // Last bit joins the word in the cycle it arrives
   assign word_done = s.armed && sclk_fall &&
                      (s.cnt == LAST_BIT);
   assign word = {s.shreg, s.d2};

   // Field split of the completed word
   assign ch = word[CH_HI:CH_LO];
   assign op = qd_op_t'(word[OP_HI:OP_LO]);
   assign code = word[CODE_HI:CODE_LO];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;

      // Two flops on each pin before any use
      next_s.f1 = link.frame_n;
      next_s.f2 = s.f1;
      next_s.fp = s.f2;
      next_s.c1 = link.sclk;
      next_s.c2 = s.c1;
      next_s.cp = s.c2;
      next_s.d1 = link.serial_data_in;
      next_s.d2 = s.d1;

      // Wake-up countdown after power-down ends
      if (s.wake != 4'h0) begin
         next_s.wake = s.wake - 4'h1;
      end

      // Frame tracking; high frame drops partial word
      if (frame_high) begin
         next_s.armed = 1'b0;
         next_s.cnt = 4'h0;
      end else if (frame_fall) begin
         next_s.armed = 1'b1;
         next_s.cnt = 4'h0;
      end else if (s.armed && sclk_fall) begin
         // Most significant bit enters first
         next_s.shreg = {s.shreg[13:0], s.d2};
         next_s.cnt = s.cnt + 4'h1;
         if (word_done) begin
            // Disarm: clocks ignored until next frame
            next_s.armed = 1'b0;
            next_s.cnt = 4'h0;
         end
      end

      // Command execution on the sixteenth fall
      if (word_done) begin
         case (op)
            OP_LOAD: begin
               // Staged only, outputs untouched
               next_s.in_reg[ch] = code;
            end
            OP_LOAD_UPD: begin
               next_s.in_reg[ch] = code;
               next_s.dac_reg = next_s.in_reg;
            end
            OP_ALL_UPD: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  next_s.in_reg[i] = code;
               end
               next_s.dac_reg = next_s.in_reg;
            end
            OP_PWRDN: begin
               // Whole part sleeps whatever channel named
               next_s.pd = 1'b1;
               next_s.wake = 4'h0;
               case (ch)
                  2'b01: next_s.term = TERM_2K5;
                  2'b10: next_s.term = TERM_100K;
                  default: next_s.term = TERM_HIZ;
               endcase
            end
            default: next_s.pd = s.pd;
         endcase
         // Any other word ends power-down; registers
         // hold their values, only loads change them
         if (op != OP_PWRDN && s.pd) begin
            next_s.pd = 1'b0;
            next_s.wake = WAKE_CYC;
         end
      end

      // Output drive waits for the wake-up delay
      next_s.on = !next_s.pd && (next_s.wake == 4'h0);
   end

   // ****************************************
   // State register
   // ****************************************
   // Power-on: all codes zero, outputs on at zero volts
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Frame stages reset to the idle-low level, no false start
         s <= '0;
         s.in_reg <= {NUM_CH{CODE_RESET}};
         s.dac_reg <= {NUM_CH{CODE_RESET}};
         s.term <= TERM_HIZ;
         s.on <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Output code is the applied register, zero when off
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         out_code[i] = s.on ? s.dac_reg[i] : CODE_RESET;
      end
   end

   assign out_on = s.on;
   assign out_term = s.term;
   assign powered_down = s.pd;
endmodule
`default_nettype wire

/* qd_chk.sv */
// Checker of the host end of the serial write link
`default_nettype none
module qd_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic serial_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sclk_q;
   logic [4:0] cnt;
   // Falls of the link clock in this frame
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_q <= 1'b0;
         cnt <= 5'h00;
      end else begin
         sclk_q <= sclk;
         if (frame_n)
            cnt <= 5'h00;
         else if (sclk_q && !sclk)
            cnt <= cnt + 5'h01;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_lead;
      !sclk [*4] ##1 sclk;
   endsequence
   sequence s_high;
      sclk [*4] ##1 !sclk;
   endsequence
   AST_LEAD: assert property ($fell(frame_n) |-> s_lead)
      else $error("clock too soon after frame start");
   AST_START: assert property ($fell(frame_n) |-> !$fell(sclk))
      else $error("frame start on a clock fall");
   AST_HALF: assert property ($rose(sclk) |-> s_high)
      else $error("clock high time wrong");
   AST_GAP: assert property ($rose(frame_n) |-> frame_n [*4])
      else $error("frame high too short");
   AST_DATA: assert property ($fell(sclk) |-> $stable(serial_data_in))
      else $error("data moved at a clock fall");
   AST_COUNT: assert property ($rose(frame_n) |-> cnt inside {0, 16})
      else $error("frame closed with a wrong bit count");
   AST_STOP: assert property (cnt == 5'h10 |-> !sclk)
      else $error("clock after the last bit");
   AST_IDLE: assert property (frame_n |-> !serial_data_in && !sclk)
      else $error("lines not idle low");
endmodule
`default_nettype wire

/* test_quad_dac_serial_write_control.sv */
// Bench for both ends of the serial write link
`default_nettype none
`define CHK(a, e) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      err_count++; \
      $display("unexpected %0t %h %h", $time, (a), (e)); \
   end \
end
module test_quad_dac_serial_write_control;
   timeunit 1ns;
   timeprecision 1ns;
   import qd_pkg::*;
   logic clk, nrst, wr, rd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, s;
   logic [3:0][9:0] code_a, code_b;
   logic on_a, on_b, pd_a, pd_b;
   qd_term_t term_a, term_b;
   int err_count, num_checks;
   qd_term_t tt [4] = '{TERM_HIZ, TERM_2K5, TERM_100K, TERM_HIZ};
   qd_link_if lk ();
   qd_link_if lk_b ();
   qd_host u_qd_host (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .link(lk.host));
   qd_dev u_qd_dev (.clk(clk), .nrst(nrst), .link(lk.dev), .out_code(code_a),
      .out_on(on_a), .out_term(term_a), .powered_down(pd_a));
   // Second device, driven by hand to break the framing
   qd_dev u_qd_dev_b (.clk(clk), .nrst(nrst), .link(lk_b.dev),
      .out_code(code_b), .out_on(on_b), .out_term(term_b),
      .powered_down(pd_b));
   qd_chk u_qd_chk (.clk(clk), .nrst(nrst), .frame_n(lk.frame_n),
      .sclk(lk.sclk), .serial_data_in(lk.serial_data_in));
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ****
   // Register port tasks
   // ****
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 s = rdata;
   endtask
   // Poll busy, then let the device apply the word
   task automatic done();
      s = 32'h1;
      for (int i = 0; i < 200 && s[0]; i++)
         rreg(REG_STATUS);
      `CHK(s[0], 1'b0)
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic [15:0] w);
      wreg(REG_WORD, {16'h0, w});
      done();
   endtask
   // Hand-made frame: n falls, extra ones past sixteen
   task automatic bsend(input logic [15:0] w, input int n);
      @(posedge clk);
      lk_b.frame_n <= 1'b1;
      repeat (4) @(posedge clk);
      lk_b.frame_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         lk_b.serial_data_in <= (i < 16) ? w[15 - i] : 1'b1;
         lk_b.sclk <= 1'b1;
         repeat (4) @(posedge clk);
         lk_b.sclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      lk_b.frame_n <= 1'(n < 16);
      lk_b.serial_data_in <= ~lk_b.serial_data_in;
      repeat (8) @(posedge clk);
      #1;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      `CHK(code_a, 40'h0)
      `CHK({on_a, pd_a}, 2'b10)
      rreg(8'h08);
      `CHK(s, 32'h0)
   endtask
   task automatic t_load();
      send({2'b10, 2'b00, 10'h0c7, 2'b11});
      `CHK(code_a, 40'h0)
      send({2'b01, 2'b01, 10'h2b1, 2'b10});
      `CHK(code_a, {10'h0, 10'h0c7, 10'h2b1, 10'h0})
   endtask
   // Second word while busy must be dropped
   task automatic t_all();
      wreg(REG_WORD, {16'h0, 2'b11, 2'b10, 10'h3ff, 2'b00});
      wreg(REG_WORD, 32'h0000_1004);
      done();
      `CHK(code_a, {4{10'h3ff}})
      rreg(REG_STATUS);
      `CHK(s[15:8], 8'h03)
      rreg(REG_WORD);
      `CHK(s, {16'h0, 2'b11, 2'b10, 10'h3ff, 2'b00})
   endtask
   task automatic t_pd();
      for (int t = 0; t < 4; t++) begin
         send({t[1:0], 2'b11, 10'h0ab, 2'b00});
         `CHK({pd_a, on_a, code_a}, {2'b10, 40'h0})
         `CHK(term_a, tt[t])
      end
   endtask
   task automatic t_wake();
      int n;
      wreg(REG_WORD, {16'h0, 2'b00, 2'b00, 10'h001, 2'b00});
      for (n = 0; n < 400 && pd_a; n++) begin
         @(posedge clk);
         #1;
      end
      for (n = 0; n < 20 && !on_a; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK(n[3:0], WAKE_CYC)
      done();
      `CHK(code_a, {4{10'h3ff}})
   endtask
   task automatic t_frame();
      bsend({2'b00, 2'b10, 10'h123, 2'b00}, 20);
      `CHK(code_b, {4{10'h123}})
      bsend({2'b01, 2'b11, 12'h000}, 15);
      bsend({2'b00, 2'b10, 10'h2e4, 2'b01}, 15);
      `CHK({pd_b, on_b, code_b}, {2'b01, {4{10'h123}}})
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      lk_b.frame_n = 1'b0;
      lk_b.sclk = 1'b0;
      lk_b.serial_data_in = 1'b0;
      err_count = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_load();
      t_all();
      t_pd();
      t_wake();
      t_frame();
      end_of_test();
   end
   // Watchdog, well past the expected run
   initial begin
      #1_000_000;
      err_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
